// *** rtl/mdu_pkg.sv ***
// Shared definitions of the multiply/divide math unit: operation codes,
// cycle budgets, ALU geometry and the request/answer carriers.
// Assumes a single core clock; the sequencer drives requests on that clock.
package mdu_pkg;

    // ---------------------------------------------------------------
    // Operation codes
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        MDU_BYTE_MULTIPLY,            // A x B -> D
        MDU_WIDE_UNSIGNED_MULTIPLY,   // X x D -> Y:D unsigned
        MDU_WIDE_SIGNED_MULTIPLY,     // X x D -> Y:D signed
        MDU_WORD_UNSIGNED_DIVIDE,     // D / X unsigned
        MDU_FRACTION_DIVIDE,          // D / X as binary fraction
        MDU_LONG_UNSIGNED_DIVIDE,     // Y:D / X unsigned
        MDU_LONG_SIGNED_DIVIDE,       // Y:D / X signed
        MDU_WORD_SIGNED_DIVIDE,       // D / X signed
        MDU_SIGNED_MULT_ACCUMULATE    // acc + X x Y signed
    } mdu_op_type;

    // ---------------------------------------------------------------
    // Cycle budgets, start cycle counted as the first
    // ---------------------------------------------------------------
    localparam logic [3:0] MDU_CYC_MUL   = 4'h3;
    localparam logic [3:0] MDU_CYC_DIV   = 4'hc;
    localparam logic [3:0] MDU_CYC_LDIV  = 4'hb;
    localparam logic [3:0] MDU_CYC_MAC   = 4'hc;
    localparam logic [3:0] MDU_CNT_SKIP  = 4'h2;  // Start and done cycles not counted down
    localparam logic [3:0] MDU_CNT_RES   = 4'h1;  // Count at which the result is latched
    localparam logic [3:0] MDU_CNT_LOW   = 4'h2;  // Count at which the low MAC half is added

    // ---------------------------------------------------------------
    // ALU geometry
    // ---------------------------------------------------------------
    localparam int MDU_ALU_W  = 20;               // Full ALU width
    localparam int MDU_LANE_W = 10;               // Width of one split lane
    localparam int MDU_WORD_W = 16;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        mdu_op_type  op;          // Operation to run
        logic [15:0] y;           // Index register Y contents
        logic [15:0] d;           // Accumulator D contents
        logic [15:0] x;           // Index register X contents
        logic [31:0] acc;         // Running sum for the accumulate
    } mdu_req_type;

    typedef struct packed {
        logic [15:0] hi;          // Y (or X for word divides) destination
        logic [15:0] lo;          // D destination
        logic        div_zero;    // Divisor was zero
        logic        overflow;    // Quotient did not fit
    } mdu_res_type;

endpackage

// *** rtl/mdu_math_unit.sv ***
// Multi-cycle multiply/divide/accumulate unit of a 16-bit core.
// Assumes the sequencer holds nothing: operands are captured on the start
// pulse, and results are collected in the cycle that done is high.
`timescale 1ns/1ns

// Behaviour
// - Byte multiply gives 16 bits in 3 cycles
// - Wide unsigned multiply 32-bit product, 3 cycles
// - Wide signed multiply 32-bit product, 3 cycles
// - Word unsigned divide takes 12 cycles
// - Fraction divide gives binary fraction, 12 cycles
// - Long unsigned divide takes 11 cycles
// - Long signed divide takes 12 cycles
// - Word signed divide takes 12 cycles
// - Signed accumulate into 32 bits, 12 cycles
// - Wide multiplies return whole product in Y:D
// - ALU is 20 bits, splittable into two lanes
// - Split ALU does two operations per cycle
// - Long divide: Y:D by X, Y quotient, D remainder
module mdu_math_unit
    import mdu_pkg::*;
(
    input  wire logic        clk_sys_i,   // Core clock, 10 MHz
    input  wire logic        rst_n_i,     // Asynchronous reset, active low
    input  wire logic        start_i,     // One-cycle request strobe
    input  wire mdu_req_type req_i,       // Operation and operands
    output logic             busy_o,      // Operation in flight
    output logic             done_o,      // Final cycle of operation
    output mdu_res_type      res_o        // Registered result
);

    // -----------------------------------------------------------------
    // Reset release synchroniser
    // -----------------------------------------------------------------
    logic rst_meta_n_q;                   // First stage, read only by second
    logic rst_n;                          // Released reset used everywhere

    // Assert at once, release two edges later to avoid recovery hazards
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta_n_q <= 1'b0;
            rst_n        <= 1'b0;
        end
        else
        begin
            rst_meta_n_q <= 1'b1;
            rst_n        <= rst_meta_n_q;
        end
    end

    // -----------------------------------------------------------------
    // Sequencing state
    // -----------------------------------------------------------------
    logic [3:0]  cnt_q;                   // Cycles left before done
    logic        busy_q;                  // Operation in flight
    mdu_req_type op_q;                    // Captured request
    logic        take;                    // Request accepted this cycle
    logic [3:0]  budget;                  // Cycle budget of requested op

    // Budget lookup per operation
    always_comb
    begin
        case (req_i.op)
            MDU_BYTE_MULTIPLY,
            MDU_WIDE_UNSIGNED_MULTIPLY,
            MDU_WIDE_SIGNED_MULTIPLY:   budget = MDU_CYC_MUL;
            MDU_LONG_UNSIGNED_DIVIDE:   budget = MDU_CYC_LDIV;
            MDU_SIGNED_MULT_ACCUMULATE: budget = MDU_CYC_MAC;
            default:                    budget = MDU_CYC_DIV;
        endcase
    end

    // Starts during a running operation are ignored
    assign take   = start_i && !busy_q;
    assign busy_o = busy_q;
    assign done_o = busy_q && (cnt_q == '0);

    // Countdown; start cycle is the first, done cycle the last
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q <= 1'b0;
            cnt_q  <= '0;
        end
        else if (take)
        begin
            busy_q <= 1'b1;
            cnt_q  <= budget - MDU_CNT_SKIP;
        end
        else if (done_o)
        begin
            busy_q <= 1'b0;
        end
        else if (busy_q)
        begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    // Operand capture; the sequencer may change its buses afterwards
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_q <= '0;
        end
        else if (take)
        begin
            op_q <= req_i;
        end
    end

    // -----------------------------------------------------------------
    // 20-bit ALU with split mode
    // -----------------------------------------------------------------
    // Split mode cuts the carry between lanes so that two 10-bit sums
    // run in the same cycle; joined mode is one 20-bit adder.
    function automatic logic [MDU_ALU_W:0] mdu_alu(
        input logic [MDU_ALU_W-1:0] a,
        input logic [MDU_ALU_W-1:0] b,
        input logic                 cin,
        input logic                 split
    );
        logic [MDU_LANE_W:0] lo_sum;
        logic [MDU_LANE_W:0] hi_sum;
        logic                mid_c;
        lo_sum = {1'b0, a[MDU_LANE_W-1:0]} + {1'b0, b[MDU_LANE_W-1:0]}
               + {{MDU_LANE_W{1'b0}}, cin};
        mid_c  = split ? 1'b0 : lo_sum[MDU_LANE_W];
        hi_sum = {1'b0, a[MDU_ALU_W-1:MDU_LANE_W]} + {1'b0, b[MDU_ALU_W-1:MDU_LANE_W]}
               + {{MDU_LANE_W{1'b0}}, mid_c};
        return {hi_sum, lo_sum[MDU_LANE_W-1:0]};
    endfunction

    // -----------------------------------------------------------------
    // Arithmetic on captured operands
    // -----------------------------------------------------------------
    logic [15:0]        byte_prod;        // A x B
    logic [31:0]        uprod;            // Unsigned 16 x 16
    logic signed [31:0] sprod;            // Signed 16 x 16 of X and D; MAC uses its own X x Y product
    logic               zero_div;         // Divisor is zero
    logic [31:0]        long_dvd;         // Y:D dividend
    logic [31:0]        uq_long;          // Long unsigned quotient
    logic [31:0]        sq_long;          // Long signed quotient
    logic [31:0]        frac_q;           // D:0 / X
    logic [MDU_ALU_W:0] mac_lo;           // Low MAC pass
    logic [MDU_ALU_W:0] mac_hi;           // High MAC pass
    logic [MDU_ALU_W:0] pair;             // Two lane sums in one pass
    logic               mac_c_q;          // Carry between MAC passes
    logic [15:0]        mac_lo_q;         // Low MAC word
    mdu_res_type        res_d;            // Next result

    assign byte_prod = 16'(op_q.d[15:8] * op_q.d[7:0]);
    assign uprod     = 32'(op_q.x * op_q.d);
    assign sprod     = 32'($signed(op_q.x) * $signed(op_q.d));
    assign zero_div  = (op_q.x == '0);
    assign long_dvd  = {op_q.y, op_q.d};
    assign uq_long   = zero_div ? '1 : long_dvd / {16'h0000, op_q.x};
    assign sq_long   = zero_div ? '1 : 32'($signed(long_dvd) / $signed({{16{op_q.x[15]}}, op_q.x}));
    assign frac_q    = zero_div ? '1 : {op_q.d, 16'h0000} / {16'h0000, op_q.x};

    // MAC add in two passes; the signed product uses X and Y operands
    assign mac_lo = mdu_alu({4'h0, op_q.acc[15:0]}, 20'(unsigned'(32'($signed(op_q.x) * $signed(op_q.y))) & 32'h0000ffff),
                            1'b0, 1'b0);
    assign mac_hi = mdu_alu({4'h0, op_q.acc[31:16]},
                            {4'h0, 16'(32'($signed(op_q.x) * $signed(op_q.y)) >> 16)},
                            mac_c_q, 1'b0);
    // Two independent sums in one cycle; the cut carry keeps a low-lane
    // wrap from leaking into the high lane
    assign pair   = mdu_alu({op_q.y[MDU_LANE_W-1:0], op_q.d[MDU_LANE_W-1:0]},
                            {op_q.x[MDU_LANE_W-1:0], op_q.x[MDU_LANE_W-1:0]}, 1'b0, 1'b1);

    // Low half of the accumulate, one pass ahead of the high half
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mac_c_q  <= 1'b0;
            mac_lo_q <= '0;
        end
        else if (busy_q && cnt_q == MDU_CNT_LOW)
        begin
            mac_c_q  <= mac_lo[MDU_WORD_W];
            mac_lo_q <= mac_lo[MDU_WORD_W-1:0];
        end
    end

    // Result selection per operation
    always_comb
    begin
        res_d = '0;
        case (op_q.op)
            MDU_BYTE_MULTIPLY:
            begin
                res_d.lo = byte_prod;
            end
            MDU_WIDE_UNSIGNED_MULTIPLY:
            begin
                {res_d.hi, res_d.lo} = uprod;
            end
            MDU_WIDE_SIGNED_MULTIPLY:
            begin
                {res_d.hi, res_d.lo} = sprod;
            end
            MDU_WORD_UNSIGNED_DIVIDE:
            begin
                res_d.hi       = zero_div ? '1 : op_q.d / op_q.x;
                res_d.lo       = zero_div ? op_q.d : op_q.d % op_q.x;
                res_d.div_zero = zero_div;
            end
            MDU_FRACTION_DIVIDE:
            begin
                res_d.hi       = frac_q[15:0];
                res_d.lo       = zero_div ? op_q.d : 16'({op_q.d, 16'h0000} % {16'h0000, op_q.x});
                res_d.div_zero = zero_div;
                res_d.overflow = !zero_div && (op_q.d >= op_q.x);
            end
            MDU_LONG_UNSIGNED_DIVIDE:
            begin
                res_d.hi       = uq_long[15:0];
                res_d.lo       = zero_div ? op_q.d : 16'(long_dvd % {16'h0000, op_q.x});
                res_d.div_zero = zero_div;
                res_d.overflow = !zero_div && (uq_long[31:16] != '0);
            end
            MDU_LONG_SIGNED_DIVIDE:
            begin
                res_d.hi       = sq_long[15:0];
                res_d.lo       = zero_div ? op_q.d :
                                 16'($signed(long_dvd) % $signed({{16{op_q.x[15]}}, op_q.x}));
                res_d.div_zero = zero_div;
                res_d.overflow = !zero_div && (sq_long[31:16] != {16{sq_long[15]}});
            end
            MDU_WORD_SIGNED_DIVIDE:
            begin
                res_d.hi       = zero_div ? '1 : 16'($signed(op_q.d) / $signed(op_q.x));
                res_d.lo       = zero_div ? op_q.d : 16'($signed(op_q.d) % $signed(op_q.x));
                res_d.div_zero = zero_div;
                res_d.overflow = !zero_div && (op_q.d == 16'h8000) && (op_q.x == 16'hffff);
            end
            MDU_SIGNED_MULT_ACCUMULATE:
            begin
                res_d.hi = mac_hi[MDU_WORD_W-1:0];
                res_d.lo = mac_lo_q;
            end
            default:
            begin
                res_d = '0;
            end
        endcase
    end

    // Result is latched one cycle before done so it stands from flip-flops
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            res_o <= '0;
        end
        else if (busy_q && cnt_q == MDU_CNT_RES)
        begin
            res_o <= res_d;
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    sequence s_take(mdu_op_type o);
        start_i && !busy_o && req_i.op == o;
    endsequence

    property p_byte_mul;
        logic [15:0] dv;
        (s_take(MDU_BYTE_MULTIPLY), dv = req_i.d) |-> !done_o ##1 !done_o ##1
            (done_o && res_o.lo == 16'(dv[15:8] * dv[7:0]));
    endproperty
    a_byte_mul: assert property (p_byte_mul) else $error("byte multiply wrong");

    property p_wide_umul;
        logic [31:0] pv;
        (s_take(MDU_WIDE_UNSIGNED_MULTIPLY), pv = 32'(req_i.x * req_i.d)) |-> ##2
            (done_o && {res_o.hi, res_o.lo} == pv);
    endproperty
    a_wide_umul: assert property (p_wide_umul) else $error("wide unsigned multiply wrong");

    property p_wide_smul;
        logic [31:0] pv;
        (s_take(MDU_WIDE_SIGNED_MULTIPLY), pv = 32'($signed(req_i.x) * $signed(req_i.d))) |-> ##2
            (done_o && {res_o.hi, res_o.lo} == pv);
    endproperty
    a_wide_smul: assert property (p_wide_smul) else $error("wide signed multiply wrong");

    property p_word_udiv;
        s_take(MDU_WORD_UNSIGNED_DIVIDE) |-> !done_o [*8] ##4 done_o;
    endproperty
    a_word_udiv: assert property (p_word_udiv) else $error("word divide timing");

    property p_long_udiv;
        logic [31:0] dv;
        logic [15:0] xv;
        (s_take(MDU_LONG_UNSIGNED_DIVIDE) && req_i.x != '0 && req_i.y < req_i.x,
         dv = {req_i.y, req_i.d}, xv = req_i.x) |-> ##10
            (done_o && res_o.hi == 16'(dv / {16'h0000, xv}) && res_o.lo == 16'(dv % {16'h0000, xv}));
    endproperty
    a_long_udiv: assert property (p_long_udiv) else $error("long unsigned divide wrong");

    property p_long_sdiv;
        s_take(MDU_LONG_SIGNED_DIVIDE) |-> ##11 done_o;
    endproperty
    a_long_sdiv: assert property (p_long_sdiv) else $error("long signed divide timing");

    property p_mac;
        logic [31:0] sv;
        (s_take(MDU_SIGNED_MULT_ACCUMULATE),
         sv = 32'(req_i.acc + 32'($signed(req_i.x) * $signed(req_i.y)))) |-> ##11
            (done_o && {res_o.hi, res_o.lo} == sv);
    endproperty
    a_mac: assert property (p_mac) else $error("accumulate wrong");

    property p_zero_div;
        (start_i && !busy_o && req_i.x == '0 && req_i.op == MDU_WORD_SIGNED_DIVIDE) |-> ##11
            (done_o && res_o.div_zero);
    endproperty
    a_zero_div: assert property (p_zero_div) else $error("zero divisor not flagged");

    property p_done_once;
        done_o |=> !done_o && !busy_o;
    endproperty
    a_done_once: assert property (p_done_once) else $error("done not single cycle");

    // Low lane wraps on its own width, high lane keeps its carry out; a carry across the cut would show
    property p_split_alu;
        busy_o |-> (pair[MDU_LANE_W-1:0] == (op_q.d[MDU_LANE_W-1:0] + op_q.x[MDU_LANE_W-1:0]))
            && (pair[MDU_ALU_W:MDU_LANE_W] == (op_q.y[MDU_LANE_W-1:0] + op_q.x[MDU_LANE_W-1:0]));
    endproperty
    a_split_alu: assert property (p_split_alu) else $error("split lanes not independent");

endmodule

// *** testbench/mdu_seq_model.sv ***
// Sequencer model: issues one operation with a one-cycle start pulse and
// collects the result in the done cycle. Assumes the unit samples on clk_sys_i.
`timescale 1ns/1ns
module mdu_seq_model
    import mdu_pkg::*;
(
    input  wire logic        clk_sys_i,   // Core clock
    input  wire logic        busy_i,      // Unit busy level
    input  wire logic        done_i,      // Unit done strobe
    input  wire mdu_res_type res_i,       // Unit result
    output mdu_req_type      req_o,       // Operation and operands
    output logic             start_o      // Request strobe
);
    // Idle until the first request
    initial
    begin
        start_o = 1'b0;
        req_o   = '0;
    end

    // Run one operation; poke raises a stray start in that cycle count
    task automatic run(input mdu_req_type rq, input int poke, output mdu_res_type rs,
                       output int cyc, output logic [1:0] tail);
        mdu_req_type pk;
        begin
            pk      = ~rq;
            pk.op   = MDU_BYTE_MULTIPLY;               // Shorter op would show if taken
            @(posedge clk_sys_i);
            start_o <= 1'b1;
            req_o   <= rq;
            cyc     = 0;                               // Cycle with start high is cycle 0
            do
            begin
                @(posedge clk_sys_i);
                cyc++;
                start_o <= (cyc == poke);              // Start while busy must be refused
                req_o   <= (cyc == poke) ? pk : ~rq;   // Operands not held past start
                #1;
            end while (done_i !== 1'b1 && cyc < 40);
            rs = res_i;                                // Collected in the done cycle
            @(posedge clk_sys_i);
            start_o <= 1'b0;
            #1;
            tail = {busy_i, done_i};
        end
    endtask
endmodule

// *** testbench/multiply_divide_math_unit_test.sv ***
// Self-checking bench of the math unit; one task per scenario.
// Assumes the sequencer model drives requests and collects results.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module multiply_divide_math_unit_test
    import mdu_pkg::*;
;
    logic        clk_sys;    // Core clock
    logic        rst_n;      // Reset, active low
    logic        start;      // Request strobe
    mdu_req_type req;        // Request
    logic        busy;       // Busy level
    logic        done;       // Done strobe
    mdu_res_type res;        // Result
    int          n_errors;   // Mismatches
    int          n_tests;    // Comparisons

    mdu_math_unit mdu_math_unit_i (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .start_i(start),
        .req_i(req), .busy_o(busy), .done_o(done), .res_o(res));
    mdu_seq_model mdu_seq_model_i (.clk_sys_i(clk_sys), .busy_i(busy), .done_i(done),
        .res_i(res), .req_o(req), .start_o(start));

    // -----------------------------------------------------------
    // Clock and watchdog
    // -----------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Whole run is some 230 cycles; a hang is cut well past that
    initial
    begin
        #(100 * 5000);
        n_errors++;
        tally_and_finish();
    end

    // Run one request and compare the answer; overflow only when cov is set
    task automatic op_check(input mdu_req_type rq, input logic [15:0] eh, input logic [15:0] el,
                            input logic ez, input logic eo, input bit cov, input logic [3:0] n,
                            input int poke);
        mdu_res_type rs;
        int          cyc;
        logic [1:0]  tail;
        begin
            mdu_seq_model_i.run(rq, poke, rs, cyc, tail);
            `CHK("cycles", int'(n) - 1, cyc)
            `CHK("hi", eh, rs.hi)
            `CHK("lo", el, rs.lo)
            `CHK("div_zero", ez, rs.div_zero)
            if (cov)
                `CHK("overflow", eo, rs.overflow)
            `CHK("busy_done_after", 2'b00, tail)
        end
    endtask

    // -----------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------
    task automatic t_reset();
        `CHK("reset_state", 36'h0, {busy, done, res})
    endtask

    task automatic t_byte_mul();
        op_check('{MDU_BYTE_MULTIPLY, 16'h0, 16'hffff, 16'h0, 32'h0}, 16'h0, 16'hfe01, 0, 0, 0, MDU_CYC_MUL, -1);
        op_check('{MDU_BYTE_MULTIPLY, 16'h0, 16'h1234, 16'h0, 32'h0}, 16'h0, 16'h03a8, 0, 0, 0, MDU_CYC_MUL, -1);
    endtask

    task automatic t_wide_mul();
        op_check('{MDU_WIDE_UNSIGNED_MULTIPLY, 16'h0, 16'hffff, 16'hffff, 32'h0},
                 16'hfffe, 16'h0001, 0, 0, 0, MDU_CYC_MUL, -1);
        op_check('{MDU_WIDE_SIGNED_MULTIPLY, 16'h0, 16'h8000, 16'hffff, 32'h0},
                 16'h0000, 16'h8000, 0, 0, 0, MDU_CYC_MUL, -1);
        op_check('{MDU_WIDE_SIGNED_MULTIPLY, 16'h0, 16'h8000, 16'h7fff, 32'h0},
                 16'hc000, 16'h8000, 0, 0, 0, MDU_CYC_MUL, -1);
    endtask

    // A stray start in mid-run must not disturb the divide
    task automatic t_word_div();
        op_check('{MDU_WORD_UNSIGNED_DIVIDE, 16'h0, 16'hffff, 16'h0007, 32'h0},
                 16'h2492, 16'h0001, 0, 0, 1, MDU_CYC_DIV, 3);
    endtask

    task automatic t_frac_div();
        op_check('{MDU_FRACTION_DIVIDE, 16'h0, 16'h0001, 16'h0003, 32'h0},
                 16'h5555, 16'h0001, 0, 0, 1, MDU_CYC_DIV, -1);
        op_check('{MDU_FRACTION_DIVIDE, 16'h0, 16'h0003, 16'h0003, 32'h0},
                 16'h0000, 16'h0000, 0, 1, 1, MDU_CYC_DIV, -1);
    endtask

    // Quotient overflow case and a stray start in the done cycle
    task automatic t_long_udiv();
        op_check('{MDU_LONG_UNSIGNED_DIVIDE, 16'h0003, 16'h0005, 16'h0100, 32'h0},
                 16'h0300, 16'h0005, 0, 0, 1, MDU_CYC_LDIV, -1);
        op_check('{MDU_LONG_UNSIGNED_DIVIDE, 16'h0100, 16'h0000, 16'h0100, 32'h0},
                 16'h0000, 16'h0000, 0, 1, 1, MDU_CYC_LDIV, 10);
    endtask

    task automatic t_long_sdiv();
        logic signed [31:0] dv;
        logic signed [31:0] q;
        logic signed [31:0] r;
        begin
            dv = -32'sd100000;
            q  = dv / 32'sd7;   // Truncation toward zero
            r  = dv % 32'sd7;   // Remainder keeps dividend sign
            op_check('{MDU_LONG_SIGNED_DIVIDE, dv[31:16], dv[15:0], 16'h0007, 32'h0},
                     q[15:0], r[15:0], 0, 0, 1, MDU_CYC_DIV, -1);
        end
    endtask

    task automatic t_word_sdiv();
        op_check('{MDU_WORD_SIGNED_DIVIDE, 16'h0, 16'hfff9, 16'h0002, 32'h0},
                 16'hfffd, 16'hffff, 0, 0, 1, MDU_CYC_DIV, -1);
        op_check('{MDU_WORD_SIGNED_DIVIDE, 16'h0, 16'h8000, 16'hffff, 32'h0},
                 16'h8000, 16'h0000, 0, 1, 1, MDU_CYC_DIV, -1);
    endtask

    // Wraps past the top of the signed range
    task automatic t_mac();
        op_check('{MDU_SIGNED_MULT_ACCUMULATE, 16'h0003, 16'h0, 16'h0002, 32'h7fffffff},
                 16'h8000, 16'h0005, 0, 0, 0, MDU_CYC_MAC, -1);
        op_check('{MDU_SIGNED_MULT_ACCUMULATE, 16'hffff, 16'h0, 16'hffff, 32'h0},
                 16'h0000, 16'h0001, 0, 0, 0, MDU_CYC_MAC, -1);
    endtask

    // Every divide code with a zero divisor keeps its cycle count
    task automatic t_div_zero();
        mdu_op_type ops [5] = '{MDU_WORD_UNSIGNED_DIVIDE, MDU_FRACTION_DIVIDE,
            MDU_LONG_UNSIGNED_DIVIDE, MDU_LONG_SIGNED_DIVIDE, MDU_WORD_SIGNED_DIVIDE};
        begin
            foreach (ops[i])
                op_check('{ops[i], 16'h0001, 16'h1234, 16'h0, 32'h0}, 16'hffff, 16'h1234, 1, 0, 0,
                         (ops[i] == MDU_LONG_UNSIGNED_DIVIDE) ? MDU_CYC_LDIV : MDU_CYC_DIV, -1);
        end
    endtask

    // Print the counts and the verdict, then stop
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial
    begin
        n_errors = 0;
        n_tests  = 0;
        rst_n    = 1'b0;
        repeat (12) @(posedge clk_sys);
        #1;
        t_reset();
        @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_byte_mul();
        t_wide_mul();
        t_word_div();
        t_frac_div();
        t_long_udiv();
        t_long_sdiv();
        t_word_sdiv();
        t_mac();
        t_div_zero();
        tally_and_finish();
    end
endmodule
